// file: src/drv_regs_defs.svh
// register offsets, field positions, masks and frame constants of the driver
`ifndef DRV_REGS_DEFS_SVH
`define DRV_REGS_DEFS_SVH

// ----------------------------------------------------------------
// frame format
// ----------------------------------------------------------------
`define FRAME_BITS 6'd24
`define CMD_LAST_BIT 6'd7
`define CNT_MAX 6'h3F

// ----------------------------------------------------------------
// ram space offsets
// ----------------------------------------------------------------
`define ADR_BRIDGE_CTL 6'h00
`define ADR_HS_CTL 6'h01
`define ADR_BR_PWM 6'h02
`define ADR_HS_PWM 6'h03
`define ADR_OC_STAT 6'h10
`define ADR_OL_STAT 6'h11
`define ADR_SUP_STAT 6'h12
`define ADR_MASK_CFG 6'h3F

// ----------------------------------------------------------------
// information space offsets and constant words
// ----------------------------------------------------------------
`define ADR_INFO_HDR 6'h00
`define ADR_INFO_REV 6'h01
`define ADR_INFO_PC1 6'h02
`define ADR_INFO_PC2 6'h03
`define ADR_FRAME_ID 6'h3E
`define FRAME_ID_WORD 16'h0200

// ----------------------------------------------------------------
// writable bits and reset values
// ----------------------------------------------------------------
`define MASK_BRIDGE_CTL 16'hFFF1
`define MASK_HS_CTL 16'hFE00
`define MASK_BR_PWM 16'hFCFC
`define MASK_HS_PWM 16'hFFFF
`define MASK_CFG 16'h000A
`define RST_REG 16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_ENABLE 0
`define BIT_BR_PWM_TOP 7
`define BIT_CFG_PWM_TOP 10
`define BIT_SGL_PWM_TOP 8
`define BIT_SGL_ON_TOP 11
`define BIT_MASK_TW 3
`define BIT_MASK_OL 1

`endif

// file: src/drv_regs_pkg.sv
// types shared by the driver control register logic
package drv_regs_pkg;

  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_READ_CLEAR, OP_READ_INFO} opcode_e;

  typedef enum logic {ST_IDLE, ST_FRAME} frame_e;

  typedef struct packed {
    frame_e state;
    logic csn_prev;
    logic sclk_prev;
    logic [5:0] cnt;
    logic [23:0] rx;
    logic [23:0] tx;
    logic [15:0] bridge_ctl;
    logic [15:0] hs_ctl;
    logic [15:0] br_pwm;
    logic [15:0] hs_pwm;
    logic [15:0] mask_cfg;
    logic chip_rst;
    logic comm_err;
    logic sdo;
    logic sdo_oe_n;
    logic [5:0] upper;
    logic [5:0] lower;
    logic [1:0] low_res;
    logic [1:0] high_res;
    logic [2:0] single;
    logic active;
  } regs_s;

endpackage

// file: src/pin_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps

module pin_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and synchronised copies
  input wire logic [W-1:0] pins,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // first stage feeds only the second
  always_comb begin
    s_d = s_q;
    s_d.meta = pins;
    s_d.stable = s_q.meta;
  end

  // register both stages
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign synced = s_q.stable;

endmodule // pin_sync

// file: src/driver_output_control_regs.sv
// serial register bank and output control of the multi-output load driver
// ----------------------------------------------------------------
// Summary of operation
// - four read/write control registers sit at ram addresses 00h to 03h.
// - status words at 10h to 12h are read only and writes leave them alone.
// - the configuration word at 3Fh masks status bits from the error flag.
// - the information space returns fixed words, the frame word 0200h at 3Eh.
// - a driver bit set without its partner bit turns its output on and a clear bit turns it off.
// - with pwm enabled a driver is on only while its pulse input is high.
// - both switches of one half bridge are never on together.
// - bridge control bits 15..4 hold upper then lower bit per output.
// - enable bit 0 selects active mode, clearing it clears every control bit.
// - a two-bit select per configurable output picks low, high or off.
// - bits 11..9 of the second register drive three single upper outputs.
// - write and read codes reach ram, the info code reaches the info space.
// - a write frame returns status then the old content of the register.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "drv_regs_defs.svh"

module driver_output_control_regs #(
  parameter logic [15:0] INFO_HDR = 16'h1000, // arbitrary value
  parameter logic [15:0] INFO_REV = 16'h0100, // arbitrary value
  parameter logic [15:0] INFO_PC1 = 16'h2000, // arbitrary value
  parameter logic [15:0] INFO_PC2 = 16'h2100 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  // pulse inputs
  input wire logic pulse_input_a,
  input wire logic pulse_input_b,
  // diagnosis from protection logic
  input wire logic thermal_shutdown,
  input wire logic thermal_warning,
  input wire logic supply_or_current_fault,
  input wire logic open_load_any,
  input wire logic not_ready,
  input wire logic [15:0] overcurrent_status,
  input wire logic [15:0] open_load_status,
  input wire logic [15:0] supply_status,
  // driver controls
  output logic [5:0] upper_switch,
  output logic [5:0] lower_switch,
  output logic [1:0] upper_switch_low_res,
  output logic [1:0] upper_switch_high_res,
  output logic [2:0] single_upper_output,
  output logic device_active
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // driver may conduct when pwm gating is off or its input is high
  function automatic logic pwm_ok(input logic en, input logic lvl);
    return !en || lvl;
  endfunction

  // read word for a command byte
  function automatic logic [15:0] rd_word(
    input logic [7:0] cmd,
    input drv_regs_pkg::regs_s r,
    input logic [15:0] oc,
    input logic [15:0] ol,
    input logic [15:0] sup
  );
    logic [15:0] w;
    w = 16'h0000;
    if (drv_regs_pkg::opcode_e'(cmd[7:6]) == drv_regs_pkg::OP_READ_INFO) begin
      case (cmd[5:0])
        `ADR_INFO_HDR: w = INFO_HDR;
        `ADR_INFO_REV: w = INFO_REV;
        `ADR_INFO_PC1: w = INFO_PC1;
        `ADR_INFO_PC2: w = INFO_PC2;
        `ADR_FRAME_ID: w = `FRAME_ID_WORD;
        default: w = 16'h0000;
      endcase
    end else begin
      case (cmd[5:0])
        `ADR_BRIDGE_CTL: w = r.bridge_ctl;
        `ADR_HS_CTL: w = r.hs_ctl;
        `ADR_BR_PWM: w = r.br_pwm;
        `ADR_HS_PWM: w = r.hs_pwm;
        `ADR_OC_STAT: w = oc;
        `ADR_OL_STAT: w = ol;
        `ADR_SUP_STAT: w = sup;
        `ADR_MASK_CFG: w = r.mask_cfg;
        default: w = 16'h0000;
      endcase
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic csn_s;
  logic sclk_s;
  logic sdi_s;
  logic pwm_a_s;
  logic pwm_b_s;

  pin_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pins({!chip_select_n, sclk, sdi, pulse_input_a, pulse_input_b}), // select enters inverted
    .synced(pins_s)
  );

  assign {csn_s, sclk_s, sdi_s, pwm_a_s, pwm_b_s} = pins_s ^ 5'h10; // flop reset reads as idle

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  drv_regs_pkg::regs_s s_q;
  drv_regs_pkg::regs_s s_d;

  logic csn_fall;
  logic csn_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] gstat;
  logic gl_err;
  logic gate;

  // frame edges seen on the synchronised pins
  assign csn_fall = s_q.csn_prev && !csn_s;
  assign csn_rise = !s_q.csn_prev && csn_s;
  assign sclk_rise = !s_q.sclk_prev && sclk_s && !csn_s;
  assign sclk_fall = s_q.sclk_prev && !sclk_s && !csn_s;

  // global status byte, masked bits do not raise the error flag
  assign gl_err = s_q.comm_err || s_q.chip_rst || thermal_shutdown || supply_or_current_fault
    || not_ready || (thermal_warning && !s_q.mask_cfg[`BIT_MASK_TW])
    || (open_load_any && !s_q.mask_cfg[`BIT_MASK_OL]);
  assign gstat = {gl_err, s_q.comm_err, !s_q.chip_rst, thermal_shutdown,
    thermal_warning && !s_q.mask_cfg[`BIT_MASK_TW], supply_or_current_fault,
    open_load_any && !s_q.mask_cfg[`BIT_MASK_OL], not_ready};

  // drivers may conduct only in active mode with no chip reset or shutdown
  assign gate = s_q.bridge_ctl[`BIT_ENABLE] && !s_q.chip_rst && !thermal_shutdown;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] cmd;
    logic [15:0] wd;
    logic in_sel;
    logic hs;
    logic ls;
    logic ok;
    logic [1:0] sel;
    cmd = s_q.rx[23:16];
    wd = s_q.rx[15:0];
    in_sel = 1'b0;
    hs = 1'b0;
    ls = 1'b0;
    ok = 1'b0;
    sel = 2'b00;
    s_d = s_q;
    s_d.csn_prev = csn_s;
    s_d.sclk_prev = sclk_s;

    // serial frame handling
    unique case (s_q.state)
      drv_regs_pkg::ST_IDLE: begin
        s_d.sdo_oe_n = 1'b1;
        if (csn_fall) begin
          s_d.state = drv_regs_pkg::ST_FRAME;
          s_d.cnt = 6'h00;
          s_d.tx = {gstat, 16'h0000};
          s_d.sdo = gstat[7];
          s_d.sdo_oe_n = 1'b0;
        end
      end
      drv_regs_pkg::ST_FRAME: begin
        if (sclk_rise) begin
          s_d.rx = {s_q.rx[22:0], sdi_s};
          if (s_q.cnt != `CNT_MAX) begin
            s_d.cnt = s_q.cnt + 6'd1;
          end
          // command byte complete: load the answer word
          if (s_q.cnt == `CMD_LAST_BIT) begin
            s_d.tx[22:7] = rd_word({s_q.rx[6:0], sdi_s}, s_q, overcurrent_status,
              open_load_status, supply_status);
          end
        end
        if (sclk_fall && s_q.cnt != 6'h00) begin
          s_d.tx = {s_q.tx[22:0], 1'b0};
          s_d.sdo = s_q.tx[22];
        end
        if (csn_rise) begin
          s_d.state = drv_regs_pkg::ST_IDLE;
          s_d.sdo_oe_n = 1'b1;
          if (s_q.cnt == `FRAME_BITS) begin
            s_d.comm_err = 1'b0;
            s_d.chip_rst = 1'b0;
            if (drv_regs_pkg::opcode_e'(cmd[7:6]) == drv_regs_pkg::OP_WRITE) begin
              case (cmd[5:0])
                `ADR_BRIDGE_CTL: begin
                  if (!wd[`BIT_ENABLE]) begin
                    s_d.bridge_ctl = `RST_REG;
                    s_d.hs_ctl = `RST_REG;
                    s_d.br_pwm = `RST_REG;
                    s_d.hs_pwm = `RST_REG;
                  end else begin
                    s_d.bridge_ctl = wd & `MASK_BRIDGE_CTL;
                  end
                end
                `ADR_HS_CTL: begin
                  if (s_q.bridge_ctl[`BIT_ENABLE]) begin
                    s_d.hs_ctl = wd & `MASK_HS_CTL;
                  end
                end
                `ADR_BR_PWM: begin
                  if (s_q.bridge_ctl[`BIT_ENABLE]) begin
                    s_d.br_pwm = wd & `MASK_BR_PWM;
                  end
                end
                `ADR_HS_PWM: begin
                  if (s_q.bridge_ctl[`BIT_ENABLE]) begin
                    s_d.hs_pwm = wd & `MASK_HS_PWM;
                  end
                end
                `ADR_MASK_CFG: s_d.mask_cfg = wd & `MASK_CFG;
                default: s_d.mask_cfg = s_q.mask_cfg; // status and unmapped ignored
              endcase
            end
          end else begin
            s_d.comm_err = 1'b1;
          end
        end
      end
    endcase

    // half bridges, upper bit above lower bit per output
    for (int i = 0; i < 6; i++) begin
      hs = s_q.bridge_ctl[15 - 2 * i];
      ls = s_q.bridge_ctl[14 - 2 * i];
      in_sel = (i == 4) ? pwm_b_s : pwm_a_s;
      ok = gate && pwm_ok(s_q.br_pwm[`BIT_BR_PWM_TOP - i], in_sel);
      s_d.upper[i] = hs && !ls && ok;
      s_d.lower[i] = ls && !hs && ok;
    end

    // configurable upper outputs, two-bit resistance select
    for (int k = 0; k < 2; k++) begin
      sel = s_q.hs_ctl[15 - 2 * k -: 2];
      in_sel = (k == 1) ? pwm_b_s : pwm_a_s;
      ok = gate && pwm_ok(s_q.hs_pwm[`BIT_CFG_PWM_TOP - k], in_sel);
      s_d.low_res[k] = (sel == 2'b10) && ok;
      s_d.high_res[k] = (sel == 2'b01) && ok;
    end

    // single upper outputs
    for (int j = 0; j < 3; j++) begin
      in_sel = (j == 1) ? pwm_b_s : pwm_a_s;
      ok = gate && pwm_ok(s_q.hs_pwm[`BIT_SGL_PWM_TOP - j], in_sel);
      s_d.single[j] = s_q.hs_ctl[`BIT_SGL_ON_TOP - j] && ok;
    end

    s_d.active = gate;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= drv_regs_pkg::ST_IDLE;
      s_q.csn_prev <= 1'b1;
      s_q.chip_rst <= 1'b1;
      s_q.sdo_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign sdo = s_q.sdo;
  assign sdo_oe_n = s_q.sdo_oe_n;
  assign upper_switch = s_q.upper;
  assign lower_switch = s_q.lower;
  assign upper_switch_low_res = s_q.low_res;
  assign upper_switch_high_res = s_q.high_res;
  assign single_upper_output = s_q.single;
  assign device_active = s_q.active;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_cmd_done;
    s_q.state == drv_regs_pkg::ST_FRAME && sclk_rise && s_q.cnt == `CMD_LAST_BIT;
  endsequence

  sequence s_bad_end;
    s_q.state == drv_regs_pkg::ST_FRAME && csn_rise && s_q.cnt != `FRAME_BITS;
  endsequence

  property p_no_shoot;
    @(posedge clk) disable iff (rst)
    (upper_switch & lower_switch) == 6'h00;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("bridge shoot-through");

  property p_standby_clear;
    @(posedge clk) disable iff (rst)
    !s_q.bridge_ctl[0] |-> (s_q.bridge_ctl | s_q.hs_ctl | s_q.br_pwm | s_q.hs_pwm) == 16'h0;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby left bits");

  property p_off_idle;
    @(posedge clk) disable iff (rst)
    !gate |=> upper_switch == 6'h00 && single_upper_output == 3'h0 && !device_active;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("driver on while gated");

  property p_pwm_gate;
    @(posedge clk) disable iff (rst)
    s_q.br_pwm[7] && !pwm_a_s |=> !upper_switch[0] && !lower_switch[0];
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pwm low yet on");

  property p_bad_frame;
    @(posedge clk) disable iff (rst)
    s_bad_end |=> s_q.comm_err && $stable(s_q.bridge_ctl) && $stable(s_q.hs_ctl);
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame changed state");

  property p_res_off;
    @(posedge clk) disable iff (rst)
    s_q.hs_ctl[15:14] == 2'b11 |=> !upper_switch_low_res[0] && !upper_switch_high_res[0];
  endproperty
  a_res_off: assert property (p_res_off) else $error("select 11 not off");

  property p_frame_id;
    @(posedge clk) disable iff (rst)
    s_cmd_done ##0 ({s_q.rx[6:0], sdi_s} == 8'hFE) |=> s_q.tx[22:7] == 16'h0200;
  endproperty
  a_frame_id: assert property (p_frame_id) else $error("frame word wrong");

  property p_old_value;
    @(posedge clk) disable iff (rst)
    s_cmd_done ##0 ({s_q.rx[6:0], sdi_s} == 8'h00) |=> s_q.tx[22:7] == $past(s_q.bridge_ctl);
  endproperty
  a_old_value: assert property (p_old_value) else $error("old content not returned");

  property p_single;
    @(posedge clk) disable iff (rst)
    gate && s_q.hs_ctl[11] && !s_q.hs_pwm[8] |=> single_upper_output[0];
  endproperty
  a_single: assert property (p_single) else $error("single output not on");

endmodule // driver_output_control_regs

// file: verif/spi_host_model.sv
// serial master model standing in for the host controller
`timescale 1ns/1ps

module spi_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic chip_select_n,
  output logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sdi
);
  logic last_q;
  logic line;

  // a released data line shows the inverse of its last driven level
  always_ff @(posedge clk) begin
    if (!sdo_oe_n) begin
      last_q <= sdo;
    end
  end
  assign line = sdo_oe_n ? ~last_q : sdo;

  // pins idle with select high and clock still
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // one mode 0 frame, msb first; nclk other than 24 makes a bad frame
  task automatic xfer(input logic [23:0] word, input int nclk, output logic [23:0] resp);
    resp = 24'h000000;
    @(posedge clk);
    #1 chip_select_n = 1'b0;
    sdi = word[23];
    for (int i = 0; i < nclk; i++) begin
      repeat (6) @(posedge clk);
      resp = {resp[22:0], line};
      #1 sclk = 1'b1;
      repeat (6) @(posedge clk);
      #1 sclk = 1'b0;
      sdi = (i < 23) ? word[22 - i] : ~sdi;
    end
    repeat (6) @(posedge clk);
    #1 chip_select_n = 1'b1;
    sdi = ~sdi;
    repeat (6) @(posedge clk);
  endtask
endmodule // spi_host_model

// file: verif/driver_output_control_regs_tb.sv
// self-checking bench for the driver control register bank
`timescale 1ns/1ps
`include "drv_regs_defs.svh"

module driver_output_control_regs_tb;
  localparam logic [15:0] HDR = 16'h1A01; // arbitrary value
  localparam logic [15:0] REV = 16'h1A02; // arbitrary value
  localparam logic [15:0] PC1 = 16'h1A03; // arbitrary value
  localparam logic [15:0] PC2 = 16'h1A04; // arbitrary value
  localparam logic [1:0] WR = drv_regs_pkg::OP_WRITE;
  localparam logic [1:0] RD = drv_regs_pkg::OP_READ;
  localparam logic [1:0] INF = drv_regs_pkg::OP_READ_INFO;
  logic clk, rst, chip_select_n, sclk, sdi, sdo, sdo_oe_n, pulse_a, pulse_b;
  logic tsd, tw, fault, ol_any, nr, device_active;
  logic [15:0] oc_w, ol_w, sup_w;
  logic [5:0] upper, lower;
  logic [1:0] low_res, high_res;
  logic [2:0] single;
  logic [23:0] r;
  int num_errors, check_count, cycles;

  driver_output_control_regs #(.INFO_HDR(HDR), .INFO_REV(REV), .INFO_PC1(PC1),
    .INFO_PC2(PC2)) dut (.clk(clk), .rst(rst), .chip_select_n(chip_select_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .pulse_input_a(pulse_a),
    .pulse_input_b(pulse_b), .thermal_shutdown(tsd), .thermal_warning(tw),
    .supply_or_current_fault(fault), .open_load_any(ol_any), .not_ready(nr),
    .overcurrent_status(oc_w), .open_load_status(ol_w), .supply_status(sup_w),
    .upper_switch(upper), .lower_switch(lower), .upper_switch_low_res(low_res),
    .upper_switch_high_res(high_res), .single_upper_output(single),
    .device_active(device_active));

  spi_host_model host (.clk(clk), .chip_select_n(chip_select_n), .sclk(sclk),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sdi(sdi));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // cuts a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic [1:0] code, input logic [5:0] adr, input logic [15:0] d);
    host.xfer({code, adr, d}, 24, r);
  endtask

  // read a ram word and check it with a clean status byte
  task automatic rd_chk(input logic [5:0] adr, input logic [15:0] exp);
    acc(RD, adr, 16'h0000);
    chk({8'h00, r}, {8'h00, 8'h20, exp}, "read word");
  endtask

  task automatic outs(input logic [5:0] up, lo, input logic [1:0] lr, hr,
      input logic [2:0] sg, input logic act);
    repeat (6) @(posedge clk);
    chk({12'h000, upper, lower, low_res, high_res, single, device_active},
      {12'h000, up, lo, lr, hr, sg, act}, "driver outputs");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({12'h000, upper, lower, low_res, high_res, single, device_active}, 0, "reset outs");
    chk({31'h0, sdo_oe_n}, 32'h1, "data line not released");
    acc(RD, `ADR_BRIDGE_CTL, 16'h0000);
    chk({8'h00, r}, 32'h00800000, "first frame");
    for (int a = 1; a < 4; a++) rd_chk(a[5:0], 16'h0000);
    rd_chk(`ADR_MASK_CFG, 16'h0000);
  endtask

  task automatic t_info();
    logic [15:0] exp [5];
    logic [5:0] adr [5];
    exp = '{HDR, REV, PC1, PC2, 16'h0200};
    adr = '{`ADR_INFO_HDR, `ADR_INFO_REV, `ADR_INFO_PC1, `ADR_INFO_PC2, `ADR_FRAME_ID};
    for (int i = 0; i < 5; i++) begin
      acc(INF, adr[i], 16'h0000);
      chk({8'h00, r}, {16'h0020, exp[i]}, "info word");
    end
  endtask

  task automatic t_bridge();
    acc(WR, `ADR_BRIDGE_CTL, 16'h8001);
    chk({8'h00, r}, 32'h00200000, "old content");
    outs(6'h01, 6'h00, 2'b00, 2'b00, 3'b000, 1'b1);
    acc(WR, `ADR_BRIDGE_CTL, 16'h6901);
    chk({16'h0000, r[15:0]}, 32'h00008001, "old content");
    outs(6'h06, 6'h09, 2'b00, 2'b00, 3'b000, 1'b1);
    acc(WR, `ADR_BRIDGE_CTL, 16'hF551);
    outs(6'h00, 6'h3C, 2'b00, 2'b00, 3'b000, 1'b1);
    rd_chk(`ADR_BRIDGE_CTL, 16'hF551);
  endtask

  task automatic t_high();
    logic [1:0] sa, sb;
    logic [2:0] sg;
    for (int k = 0; k < 4; k++) begin
      sa = 2'(k);
      sb = 2'(3 - k);
      sg = 3'(7 - k);
      acc(WR, `ADR_HS_CTL, {sa, sb, sg, 9'h000});
      outs(6'h00, 6'h3C, {sb == 2'b10, sa == 2'b10}, {sb == 2'b01, sa == 2'b01},
        {sg[0], sg[1], sg[2]}, 1'b1);
    end
  endtask

  task automatic t_pwm();
    logic a, b;
    acc(WR, `ADR_BRIDGE_CTL, 16'hAAA1);
    acc(WR, `ADR_HS_CTL, 16'hAE00);
    acc(WR, `ADR_BR_PWM, 16'h00FC);
    acc(WR, `ADR_HS_PWM, 16'h07C0);
    for (int j = 0; j < 4; j++) begin
      a = j[0];
      b = j[1];
      @(posedge clk);
      #1 pulse_a = a;
      pulse_b = b;
      outs({a, b, a, a, a, a}, 6'h00, {b, a}, 2'b00, {a, b, a}, 1'b1);
    end
    @(posedge clk);
    #1 tsd = 1'b1;
    outs(6'h00, 6'h00, 2'b00, 2'b00, 3'b000, 1'b0);
    acc(RD, `ADR_BRIDGE_CTL, 16'h0000);
    chk({24'h0, r[23:16]}, 32'hB0, "status byte");
    @(posedge clk);
    #1 tsd = 1'b0;
  endtask

  task automatic t_status();
    logic [5:0] adr [3];
    logic [15:0] exp [3];
    adr = '{`ADR_OC_STAT, `ADR_OL_STAT, `ADR_SUP_STAT};
    exp = '{oc_w, ol_w, sup_w};
    for (int i = 0; i < 3; i++) begin
      acc(WR, adr[i], 16'hFFFF);
      rd_chk(adr[i], exp[i]);
    end
    acc(drv_regs_pkg::OP_READ_CLEAR, `ADR_OC_STAT, 16'h0000);
    chk({8'h00, r}, {16'h0020, oc_w}, "read and clear");
    @(posedge clk);
    #1 tw = 1'b1;
    ol_any = 1'b1;
    acc(WR, `ADR_MASK_CFG, 16'hFFFF);
    rd_chk(`ADR_MASK_CFG, 16'h000A);
    acc(WR, `ADR_MASK_CFG, 16'h0000);
    acc(RD, `ADR_MASK_CFG, 16'h0000);
    chk({24'h0, r[23:16]}, 32'hAA, "unmasked status");
    @(posedge clk);
    #1 fault = 1'b1;
    nr = 1'b1;
    acc(RD, `ADR_MASK_CFG, 16'h0000);
    chk({24'h0, r[23:16]}, 32'hAF, "all status bits");
    @(posedge clk);
    #1 tw = 1'b0;
    ol_any = 1'b0;
    fault = 1'b0;
    nr = 1'b0;
  endtask

  task automatic t_bad_frame();
    int n [2];
    n = '{23, 25};
    for (int i = 0; i < 2; i++) begin
      host.xfer({WR, `ADR_BRIDGE_CTL, 16'h0001}, n[i], r);
      acc(RD, `ADR_BRIDGE_CTL, 16'h0000);
      chk({8'h00, r}, {16'h00E0, 16'hAAA1}, "rejected frame");
      rd_chk(`ADR_BRIDGE_CTL, 16'hAAA1);
    end
  endtask

  task automatic t_disable();
    acc(WR, `ADR_BRIDGE_CTL, 16'h0000);
    outs(6'h00, 6'h00, 2'b00, 2'b00, 3'b000, 1'b0);
    for (int a = 0; a < 4; a++) rd_chk(a[5:0], 16'h0000);
    acc(WR, `ADR_HS_CTL, 16'hFE00);
    rd_chk(`ADR_HS_CTL, 16'h0000);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {pulse_a, pulse_b, tsd, tw, fault, ol_any, nr} = 7'h00;
    oc_w = 16'h0A51;
    ol_w = 16'h1B62;
    sup_w = 16'h2C73;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_info();
    t_bridge();
    t_high();
    t_pwm();
    t_status();
    t_bad_frame();
    t_disable();
    finish_test();
  end
endmodule // driver_output_control_regs_tb
